// ==== crt_timing_pkg.sv ====
// Package of format constants for the CRT raster timing block, plus the
// dot/character clock divider that the timing core instantiates.
// Assumes one 125 MHz reference clock with a synchronous active-high reset.
`default_nettype none

package crt_timing_pkg;
  // ----------------------------------------
  // Clocking
  // ----------------------------------------
  localparam int CLK_NS = 8;
  localparam int DOT_DIV = 8;
  localparam int DOT_NS = CLK_NS * DOT_DIV;
  localparam logic [4:0] DOTS_PER_CHAR = 5'h08;
  localparam int LBC_MIN_NS = 200;
  localparam int LBC_MIN_DOTS = (LBC_MIN_NS + DOT_NS - 1) / DOT_NS;
  localparam logic [4:0] LBC_LOW_DOTS = 5'((int'(DOTS_PER_CHAR) + 1) / 2);
  localparam int CHAR_CYCLES = DOT_DIV * int'(DOTS_PER_CHAR);
  // ----------------------------------------
  // Horizontal format, in character times
  // ----------------------------------------
  localparam logic [6:0] CHARS_VIDEO = 7'h50;
  localparam logic [6:0] CHARS_TOTAL = 7'h64;
  localparam logic [6:0] HSYNC_DELAY = 7'h02;
  localparam logic [6:0] HSYNC_WIDTH = 7'h09;
  localparam logic [6:0] SERR_WIDTH = 7'h04;
  localparam logic SERR_EN = 1'b1;
  localparam logic HSYNC_LEVEL = 1'b0;
  // ----------------------------------------
  // Vertical format, in scan lines
  // ----------------------------------------
  localparam logic [4:0] LINES_PER_ROW = 5'h0a;
  localparam logic [3:0] LAST_SCAN = 4'(int'(LINES_PER_ROW) - 1);
  localparam int VIDEO_ROWS = 24;
  localparam logic [8:0] VIDEO_LINES = 9'(int'(LINES_PER_ROW) * VIDEO_ROWS);
  localparam logic [8:0] VBLANK_LINES_F1 = 9'h016;
  localparam logic [8:0] VBLANK_LINES_F0 = 9'h048;
  localparam int FRAME_LINES_MAX = 512;
  localparam logic [8:0] VSYNC_DELAY = 9'h004;
  localparam logic [8:0] VSYNC_WIDTH = 9'h003;
  localparam logic [8:0] VBLANK_STOP = 9'h000;
  localparam logic VSYNC_LEVEL = 1'b0;
  localparam logic VBLANK_LEVEL = 1'b1;
  // ----------------------------------------
  // Cursor and register select
  // ----------------------------------------
  localparam logic CURSOR_ALL = 1'b1;
  localparam logic [3:0] CURSOR_LINE = 4'h0;
  localparam logic [1:0] SEL_ROW_BEGIN = 2'h0;
  localparam logic [1:0] SEL_PAGE_START = 2'h1;
  localparam logic [1:0] SEL_CURSOR = 2'h2;
endpackage

module crt_char_divider
(
  input wire logic clk,
  input wire logic srst,
  output logic char_en,
  output logic lb_clk
);
  typedef struct packed {
    logic [2:0] pre;
    logic [3:0] dot;
    logic char_en;
    logic lb_clk;
  } div_t;

  div_t s_q;
  div_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.char_en = 1'b0;
    if (s_q.pre == 3'(crt_timing_pkg::DOT_DIV - 1))
    begin
      s_d.pre = 3'h0;
      if (s_q.dot == 4'(int'(crt_timing_pkg::DOTS_PER_CHAR) - 1)) // [R27]
      begin
        s_d.dot = 4'h0;
        s_d.char_en = 1'b1;
      end
      else
        s_d.dot = s_q.dot + 4'h1;
    end
    else
      s_d.pre = s_q.pre + 3'h1;
    s_d.lb_clk = ({1'b0, s_d.dot} >= crt_timing_pkg::LBC_LOW_DOTS); // [R17]
    if (srst)
      s_d = '0;
  end

  always_ff @(posedge clk)
  begin
    s_q <= s_d;
  end

  assign char_en = s_q.char_en;
  assign lb_clk = s_q.lb_clk;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_CHAR_PERIOD: assert property (char_en |-> ##64 char_en) // [R27]
    else $error("character enable period wrong");
  AST_LBC_LOW: assert property ($fell(lb_clk) |-> ##31 !lb_clk ##1 lb_clk) // [R17]
    else $error("line buffer clock low width wrong");
endmodule

`default_nettype wire

// ==== crt_row_address_timing.sv ====
// Raster timing and video RAM address generation for a character CRT.
// Assumes REF_CLK at 125 MHz, SRST synchronous active high, inputs synchronous.
//
// How it works
// [R1] Mode low: new row starts previous row's last line
// [R2] Mode high: new row starts on its first line
// [R3] Half page: each row address sequence shown twice
// [R4] Repeated row: load and cursor outputs held inactive
// [R5] Full page: every row gets distinct addresses
// [R6] Test clock input absent; internal divider only
// [R7] Reset stops all raster and address sequencing
// [R8] Reset places sequencing at vertical blanking start
// [R9] Reset clears page start and cursor registers
// [R10] After reset: blanking, then video from zero
// [R11] Reset source holds reset at least 250 ns
// [R12] Cell width four to sixteen dots
// [R13] Two to sixteen scan lines per row
// [R14] Frame never exceeds 512 scan lines
// [R15] Video 5..122 chars, total 6..123 chars
// [R16] Vertical blanking at least one row plus two
// [R17] Line buffer clock low configured dots, min 200 ns
// [R18] Vertical blanking ends configured lines before video
// [R19] Cursor on all lines or one chosen line
// [R20] Vertical sync delay, width and level configured
// [R21] Horizontal sync delay, width and level configured
// [R22] Optional serration pulses during vertical sync
// [R23] Pin picks one of two frame rates
// [R24] Cursor two char times after matching address
// [R25] Page start loads row start; blank writes redirect
// [R26] Cursor inhibited during horizontal and vertical blanking
// [R27] Char time divides dot clock; lines from chars
// [R28] Format constants checked at build time
`default_nettype none

module crt_row_address_timing
(
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic ADDR_MODE,
  input wire logic FULL_ROW,
  input wire logic REFRESH_SEL,
  input wire logic LOAD_STROBE,
  input wire logic [1:0] LOAD_SEL,
  input wire logic [11:0] LOAD_DATA,
  output logic [11:0] ADDR,
  output logic [3:0] LINE_COUNT,
  output logic HSYNC,
  output logic VSYNC,
  output logic VBLANK,
  output logic HBLANK,
  output logic CURSOR_EN,
  output logic LOAD_VSR,
  output logic LB_RECIRC_EN,
  output logic LB_CLK
);
  // ----------------------------------------
  // Build-time format checks
  // ----------------------------------------
  if (crt_timing_pkg::DOTS_PER_CHAR < 5'h04 || crt_timing_pkg::DOTS_PER_CHAR > 5'h10) // [R12]
    $error("dots per character out of range"); // [R28]
  if (crt_timing_pkg::LINES_PER_ROW < 5'h02 || crt_timing_pkg::LINES_PER_ROW > 5'h10) // [R13]
    $error("scan lines per row out of range");
  if (int'(crt_timing_pkg::VIDEO_LINES) + int'(crt_timing_pkg::VBLANK_LINES_F0) > crt_timing_pkg::FRAME_LINES_MAX
      || int'(crt_timing_pkg::VIDEO_LINES) + int'(crt_timing_pkg::VBLANK_LINES_F1) > crt_timing_pkg::FRAME_LINES_MAX)
    $error("too many scan lines per frame"); // [R14]
  if (crt_timing_pkg::CHARS_VIDEO < 7'h05 || crt_timing_pkg::CHARS_VIDEO > 7'h7a
      || crt_timing_pkg::CHARS_TOTAL < 7'h06 || crt_timing_pkg::CHARS_TOTAL > 7'h7b
      || crt_timing_pkg::CHARS_TOTAL <= crt_timing_pkg::CHARS_VIDEO)
    $error("character times per line out of range"); // [R15]
  if (int'(crt_timing_pkg::VBLANK_LINES_F1) < int'(crt_timing_pkg::LINES_PER_ROW) + 2
      || int'(crt_timing_pkg::VBLANK_LINES_F0) < int'(crt_timing_pkg::LINES_PER_ROW) + 2)
    $error("vertical blanking too short"); // [R16]
  if (int'(crt_timing_pkg::LBC_LOW_DOTS) < crt_timing_pkg::LBC_MIN_DOTS
      || crt_timing_pkg::LBC_LOW_DOTS >= crt_timing_pkg::DOTS_PER_CHAR)
    $error("line buffer clock low width out of range"); // [R17]
  if (int'(crt_timing_pkg::VBLANK_STOP) > int'(crt_timing_pkg::LINES_PER_ROW) - 1) // [R18]
    $error("vertical blanking stop out of range");
  if (!crt_timing_pkg::CURSOR_ALL && crt_timing_pkg::VBLANK_STOP > 9'h001
      && crt_timing_pkg::VBLANK_STOP != {5'h00, crt_timing_pkg::CURSOR_LINE}) // [R19]
    $error("single cursor line conflicts with blanking stop");

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [6:0] hcnt;
    logic [8:0] vline;
    logic [3:0] vscan;
    logic f1;
    logic a_active;
    logic [3:0] a_scan;
    logic rep_row;
    logic [11:0] page_start;
    logic [11:0] row_begin;
    logic [11:0] cursor;
    logic [11:0] addr;
    logic [1:0] cur_pipe;
    logic [1:0] ld_pipe;
    logic hsync;
    logic vsync;
    logic vblank;
    logic hblank;
    logic cursor_en;
    logic load_vsr;
    logic recirc;
  } st_t;

  st_t s_q;
  st_t s_d;
  logic char_en;
  logic lb_clk;
  logic line_end;
  logic [8:0] vbl;
  logic [8:0] total;
  logic [8:0] nv;
  logic [9:0] na;
  logic q_vvideo;
  logic hit;
  logic show;

  // Test clock input is not provided; timing comes only from the divider
  crt_char_divider u_div // [R6]
  (
    .clk(REF_CLK),
    .srst(SRST),
    .char_en(char_en),
    .lb_clk(lb_clk)
  );

  // ----------------------------------------
  // Frame geometry helpers
  // ----------------------------------------
  assign vbl = s_q.f1 ? crt_timing_pkg::VBLANK_LINES_F1 : crt_timing_pkg::VBLANK_LINES_F0; // [R23]
  assign total = crt_timing_pkg::VIDEO_LINES + vbl; // [R23]
  assign line_end = char_en && s_q.hcnt == crt_timing_pkg::CHARS_TOTAL - 7'h01; // [R27]
  assign nv = (s_q.vline == total - 9'h001) ? 9'h000 : s_q.vline + 9'h001;
  // Addressing runs one line early when the mode input is low
  assign na = {1'b0, nv} + {9'h000, ~ADDR_MODE}; // [R1] [R2]
  assign q_vvideo = s_q.vline >= vbl;
  assign show = s_q.a_active && !s_q.rep_row && s_q.hcnt < crt_timing_pkg::CHARS_VIDEO; // [R4]
  assign hit = show && s_q.addr == s_q.cursor
               && (crt_timing_pkg::CURSOR_ALL || s_q.a_scan == crt_timing_pkg::CURSOR_LINE); // [R19] [R24]

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic hblank_n;
    logic vvideo_n;
    logic vs_on;
    logic hs_on;
    logic in_hs;
    logic in_serr;
    logic [6:0] hs_start;
    s_d = s_q;
    hblank_n = 1'b0;
    vvideo_n = 1'b0;
    vs_on = 1'b0;
    hs_on = 1'b0;
    in_hs = 1'b0;
    in_serr = 1'b0;
    hs_start = crt_timing_pkg::CHARS_VIDEO + crt_timing_pkg::HSYNC_DELAY;

    // Writes to row start during vertical blanking go to page start
    if (LOAD_STROBE)
    begin
      unique case (LOAD_SEL)
        crt_timing_pkg::SEL_ROW_BEGIN:
        begin
          if (!q_vvideo)
            s_d.page_start = LOAD_DATA; // [R25]
          else
            s_d.row_begin = LOAD_DATA;
        end
        crt_timing_pkg::SEL_PAGE_START:
          s_d.page_start = LOAD_DATA;
        crt_timing_pkg::SEL_CURSOR:
          s_d.cursor = LOAD_DATA;
        default:
          s_d.cursor = s_q.cursor;
      endcase
    end

    if (char_en)
    begin
      s_d.hcnt = line_end ? 7'h00 : s_q.hcnt + 7'h01; // [R27]
      if (s_q.hcnt < crt_timing_pkg::CHARS_VIDEO - 7'h01)
        s_d.addr = s_q.addr + 12'h001;
      s_d.cur_pipe = {s_q.cur_pipe[0], hit}; // [R24]
      s_d.ld_pipe = {s_q.ld_pipe[0], show}; // [R4]
    end

    if (line_end)
    begin
      s_d.vline = nv;
      if (nv == 9'h000)
        s_d.f1 = REFRESH_SEL; // [R23]
      if (nv == vbl - {4'h0, crt_timing_pkg::LINES_PER_ROW} || s_q.vscan == crt_timing_pkg::LAST_SCAN)
        s_d.vscan = 4'h0;
      else
        s_d.vscan = s_q.vscan + 4'h1;
      // Internal row start load takes a page start written in the same cycle
      if (na == {1'b0, vbl})
      begin
        s_d.a_active = 1'b1; // [R1] [R2]
        s_d.a_scan = 4'h0;
        s_d.rep_row = 1'b0;
        s_d.row_begin = s_d.page_start; // [R25] [R10]
      end
      else if (na >= {1'b0, total} || na < {1'b0, vbl})
        s_d.a_active = 1'b0;
      else if (s_q.a_active)
      begin
        if (s_q.a_scan == crt_timing_pkg::LAST_SCAN)
        begin
          s_d.a_scan = 4'h0;
          s_d.rep_row = !FULL_ROW && !s_q.rep_row; // [R3] [R5]
          if (!s_d.rep_row)
            s_d.row_begin = s_d.row_begin + 12'(crt_timing_pkg::CHARS_VIDEO); // [R5]
        end
        else
          s_d.a_scan = s_q.a_scan + 4'h1;
      end
      s_d.addr = s_d.row_begin; // [R3]
    end

    // Outputs derived from the next counters
    hblank_n = s_d.hcnt >= crt_timing_pkg::CHARS_VIDEO;
    vvideo_n = s_d.vline >= vbl;
    vs_on = s_d.vline >= crt_timing_pkg::VSYNC_DELAY
            && s_d.vline < crt_timing_pkg::VSYNC_DELAY + crt_timing_pkg::VSYNC_WIDTH; // [R20]
    in_hs = s_d.hcnt >= hs_start && s_d.hcnt < hs_start + crt_timing_pkg::HSYNC_WIDTH; // [R21]
    in_serr = s_d.hcnt >= hs_start && s_d.hcnt < hs_start + crt_timing_pkg::SERR_WIDTH;
    hs_on = (crt_timing_pkg::SERR_EN && vs_on) ? !in_serr : in_hs; // [R22]
    s_d.hsync = hs_on ? crt_timing_pkg::HSYNC_LEVEL : !crt_timing_pkg::HSYNC_LEVEL; // [R21]
    s_d.vsync = vs_on ? crt_timing_pkg::VSYNC_LEVEL : !crt_timing_pkg::VSYNC_LEVEL; // [R20]
    s_d.vblank = (s_d.vline < vbl - crt_timing_pkg::VBLANK_STOP)
                 ? crt_timing_pkg::VBLANK_LEVEL : !crt_timing_pkg::VBLANK_LEVEL; // [R18]
    s_d.hblank = hblank_n;
    s_d.cursor_en = s_d.cur_pipe[1] && !hblank_n && vvideo_n; // [R26]
    s_d.load_vsr = s_d.ld_pipe[1] && !hblank_n && vvideo_n;
    s_d.recirc = !(s_d.a_active && s_d.a_scan == 4'h0); // [R1] [R2]

    if (SRST)
    begin
      s_d = '0; // [R7] [R8] [R9]
      s_d.hsync = !crt_timing_pkg::HSYNC_LEVEL;
      s_d.vsync = !crt_timing_pkg::VSYNC_LEVEL;
      s_d.vblank = crt_timing_pkg::VBLANK_LEVEL;
      s_d.recirc = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    s_q <= s_d;
  end

  assign ADDR = s_q.addr;
  assign LINE_COUNT = s_q.vscan;
  assign HSYNC = s_q.hsync;
  assign VSYNC = s_q.vsync;
  assign VBLANK = s_q.vblank;
  assign HBLANK = s_q.hblank;
  assign CURSOR_EN = s_q.cursor_en;
  assign LOAD_VSR = s_q.load_vsr;
  assign LB_RECIRC_EN = s_q.recirc;
  assign LB_CLK = lb_clk;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  AST_RESET_CLEAR: assert property (disable iff (1'b0) SRST |=> s_q.vline == 9'h000 // [R9]
      && s_q.page_start == 12'h000 && s_q.cursor == 12'h000 && s_q.addr == 12'h000)
    else $error("reset did not clear registers");
  AST_RESET_HALT: assert property (disable iff (1'b0) SRST ##1 SRST ##1 SRST |-> $stable(s_q.hcnt) // [R7]
      && $stable(s_q.vline))
    else $error("sequencing advanced during reset");
  AST_RESET_VBLANK: assert property (disable iff (1'b0) $fell(SRST) |-> VBLANK == crt_timing_pkg::VBLANK_LEVEL // [R8]
      && !s_q.a_active)
    else $error("not in vertical blanking after reset");
  AST_ROW_LOAD: assert property (line_end && na == {1'b0, vbl} |=> // [R25]
      s_q.row_begin == $past(s_d.page_start) && ADDR == $past(s_d.page_start))
    else $error("row start not loaded from page start");
  AST_ADV_MODE: assert property (line_end && !ADDR_MODE && nv == vbl - 9'h001 |=> // [R1]
      s_q.a_active && s_q.a_scan == 4'h0 && !LB_RECIRC_EN)
    else $error("advanced addressing not started on last line");
  AST_ALIGN_MODE: assert property (line_end && ADDR_MODE && nv == vbl - 9'h001 |=> !s_q.a_active) // [R2]
    else $error("aligned addressing started early");
  AST_HALF_REPEAT: assert property ($rose(s_q.rep_row) |-> $stable(s_q.row_begin)) // [R3]
    else $error("repeated row changed its addressing");
  AST_FULL_ADV: assert property (line_end && FULL_ROW && s_q.a_active && s_q.a_scan == crt_timing_pkg::LAST_SCAN
      && na < {1'b0, total} && na != {1'b0, vbl} && !LOAD_STROBE |=> !s_q.rep_row
      && s_q.row_begin == 12'($past(s_q.row_begin) + 12'(crt_timing_pkg::CHARS_VIDEO))) // [R5]
    else $error("full page row did not advance");
  AST_REPEAT_BLANK: assert property (char_en && s_q.rep_row |=> !s_q.ld_pipe[0] && !s_q.cur_pipe[0]) // [R4]
    else $error("repeated row not blanked");
  AST_CURSOR_DELAY: assert property (char_en && hit && s_q.hcnt < crt_timing_pkg::CHARS_VIDEO - 7'h02
      && q_vvideo && s_q.hcnt != 7'h00 |-> ##65 CURSOR_EN) // [R24]
    else $error("cursor not shown two character times later");
  AST_CURSOR_BLANK: assert property (CURSOR_EN |-> !HBLANK && VBLANK != crt_timing_pkg::VBLANK_LEVEL) // [R26]
    else $error("cursor active during blanking");
  AST_HSYNC_START: assert property (char_en && s_q.hcnt == crt_timing_pkg::CHARS_VIDEO + crt_timing_pkg::HSYNC_DELAY
      - 7'h01 && VSYNC != crt_timing_pkg::VSYNC_LEVEL && nv != crt_timing_pkg::VSYNC_DELAY
      |=> HSYNC == crt_timing_pkg::HSYNC_LEVEL) // [R21]
    else $error("horizontal sync start misplaced");

  COV_HALF_PAGE: cover property ($rose(s_q.rep_row));
  COV_CURSOR: cover property ($rose(CURSOR_EN));
  COV_VSYNC: cover property (VSYNC == crt_timing_pkg::VSYNC_LEVEL && $changed(HSYNC));
  COV_RATE_F0: cover property (line_end && nv == 9'h000 && !REFRESH_SEL);
endmodule

`default_nettype wire

// ==== crt_monitor_model.sv ====
// Monitor-side model of the raster block's far side.
// It measures the scan line period from horizontal sync, and the line buffer
// clock low time in each character window.
// Assumes it sees the block's outputs on the block's own reference clock.
`default_nettype none

module crt_monitor_model
(
  input wire logic clk,
  input wire logic srst,
  input wire logic hsync,
  input wire logic vsync,
  input wire logic lb_clk,
  output var int hs_period,
  output var int lb_low
);
  timeunit 1ns;
  timeprecision 100ps;

  int cnt = 0;
  int prev = 0;
  int win = 0;
  int acc = 0;
  bit have_prev = 1'b0;
  bit vs_seen = 1'b0;
  logic hsync_d = 1'b1;

  // ----------------------------------------
  // Line period, vertical sync lines skipped
  // ----------------------------------------
  always @(posedge clk)
  begin
    cnt <= cnt + 1;
    hsync_d <= hsync;
    vs_seen <= vs_seen | ~vsync;
    if (srst)
      have_prev <= 1'b0;
    else if (hsync_d && !hsync)
    begin
      // Lines that touch vertical sync give short periods
      if (have_prev && !vs_seen && vsync)
        hs_period <= cnt - prev;
      prev <= cnt;
      have_prev <= 1'b1;
      vs_seen <= ~vsync;
    end
  end

  // ----------------------------------------
  // Line buffer clock low count
  // ----------------------------------------
  always @(posedge clk)
  begin
    win <= (win == 63) ? 0 : win + 1;
    if (win == 63)
    begin
      lb_low <= acc + (lb_clk ? 0 : 1);
      acc <= 0;
    end
    else
      acc <= acc + (lb_clk ? 0 : 1);
  end
endmodule

`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the CRT raster timing block.
// Assumes the timing package, the design and the monitor model compile first.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {int line; int chr; bit hb; bit hs; bit hc; bit vs;} row_t;

  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic addr_mode = 1'b1;
  logic full_row = 1'b1;
  logic refresh_sel = 1'b0;
  logic load_strobe = 1'b0;
  logic [1:0] load_sel = 2'h0;
  logic [11:0] load_data = 12'h000;
  logic [11:0] addr;
  logic [3:0] line_count;
  logic hsync;
  logic vsync;
  logic vblank;
  logic hblank;
  logic cursor_en;
  logic load_vsr;
  logic lb_recirc_en;
  logic lb_clk;
  int hs_period;
  int lb_low;
  int bad_count = 0;
  int num_checks = 0;
  int el = 0;
  int cycles = 0;
  row_t rows [15] = '{'{0, 10, 0, 1, 1, 1}, '{0, 79, 0, 1, 1, 1}, '{0, 80, 1, 1, 1, 1},
    '{0, 81, 1, 1, 1, 1}, '{0, 82, 1, 0, 1, 1}, '{0, 90, 1, 0, 1, 1}, '{0, 91, 1, 1, 1, 1},
    '{0, 99, 1, 1, 1, 1}, '{1, 0, 0, 1, 1, 1}, '{3, 86, 1, 0, 1, 1}, '{4, 40, 0, 0, 1, 0},
    '{5, 84, 1, 1, 1, 0}, '{6, 40, 0, 0, 1, 0}, '{7, 10, 0, 1, 1, 1}, '{7, 86, 1, 0, 1, 1}};

  crt_row_address_timing u_dut
  (
    .REF_CLK(ref_clk),
    .SRST(srst),
    .ADDR_MODE(addr_mode),
    .FULL_ROW(full_row),
    .REFRESH_SEL(refresh_sel),
    .LOAD_STROBE(load_strobe),
    .LOAD_SEL(load_sel),
    .LOAD_DATA(load_data),
    .ADDR(addr),
    .LINE_COUNT(line_count),
    .HSYNC(hsync),
    .VSYNC(vsync),
    .VBLANK(vblank),
    .HBLANK(hblank),
    .CURSOR_EN(cursor_en),
    .LOAD_VSR(load_vsr),
    .LB_RECIRC_EN(lb_recirc_en),
    .LB_CLK(lb_clk)
  );

  crt_monitor_model u_mon
  (
    .clk(ref_clk),
    .srst(srst),
    .hsync(hsync),
    .vsync(vsync),
    .lb_clk(lb_clk),
    .hs_period(hs_period),
    .lb_low(lb_low)
  );

  always #4 ref_clk = ~ref_clk;

  // ----------------------------------------
  // Compare and timing helpers
  // ----------------------------------------
  task automatic check_bit(string name, logic exp, logic got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_vec(string name, logic [11:0] exp, logic [11:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_num(string name, int exp, int got);
    num_checks++;
    if (got != exp)
    begin
      bad_count++;
      $display("ERROR %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
    el += n;
  endtask

  // Middle of the given character time
  task automatic go(int line, int chr);
    step(line * 6400 + chr * 64 + 32 - el);
  endtask

  task automatic reset_vals();
    check_vec("ADDR", 12'h000, addr);
    check_vec("LINE_COUNT", 12'h000, {8'h00, line_count});
    check_bit("HSYNC", 1'b1, hsync);
    check_bit("VSYNC", 1'b1, vsync);
    check_bit("VBLANK", 1'b1, vblank);
    check_bit("HBLANK", 1'b0, hblank);
    check_bit("CURSOR_EN", 1'b0, cursor_en);
    check_bit("LOAD_VSR", 1'b0, load_vsr);
    check_bit("LB_RECIRC_EN", 1'b1, lb_recirc_en);
    check_bit("LB_CLK", 1'b0, lb_clk);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // Hang guard
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 70000)
    begin
      bad_count++;
      test_done();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    step(2);
    reset_vals();
    srst = 1'b0;
    el = 0;
    foreach (rows[i])
    begin
      go(rows[i].line, rows[i].chr);
      check_bit("HBLANK", rows[i].hb, hblank);
      if (rows[i].hc)
        check_bit("HSYNC", rows[i].hs, hsync);
      check_bit("VSYNC", rows[i].vs, vsync);
      check_vec("LINE_COUNT", 12'(rows[i].line % int'(crt_timing_pkg::LINES_PER_ROW)),
        {8'h00, line_count});
      check_bit("VBLANK", 1'b1, vblank);
      check_bit("CURSOR_EN", 1'b0, cursor_en);
      check_bit("LOAD_VSR", 1'b0, load_vsr);
    end
    check_num("line period", int'(crt_timing_pkg::CHARS_TOTAL) * crt_timing_pkg::CHAR_CYCLES, hs_period);
    check_num("lb low", int'(crt_timing_pkg::LBC_LOW_DOTS) * crt_timing_pkg::DOT_DIV, lb_low);
    // Mid-run reset while sync is active, held past 250 ns
    srst = 1'b1;
    step(2);
    for (int i = 0; i < 31; i++)
    begin
      check_bit("HSYNC", 1'b1, hsync);
      check_bit("HBLANK", 1'b0, hblank);
      check_vec("ADDR", 12'h000, addr);
      step(1);
    end
    reset_vals();
    srst = 1'b0;
    el = 0;
    // Every register select, then mode inputs moved
    load_strobe = 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      load_sel = 2'(s);
      load_data = 12'h3c0 + 12'(s);
      step(1);
    end
    load_strobe = 1'b0;
    addr_mode = 1'b0;
    full_row = 1'b0;
    refresh_sel = 1'b1;
    go(0, 40);
    check_bit("HBLANK", 1'b0, hblank);
    check_bit("CURSOR_EN", 1'b0, cursor_en);
    go(0, 85);
    check_bit("HBLANK", 1'b1, hblank);
    check_bit("HSYNC", 1'b0, hsync);
    check_bit("VBLANK", 1'b1, vblank);
    check_bit("CURSOR_EN", 1'b0, cursor_en);
    test_done();
  end
endmodule

`default_nettype wire
